// ==== rtl/spm_pkg.sv ====
// constants and types shared by the self-programming flash control logic
package prog_ctrl_pkg;

  // register byte addresses on the apb bus
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // control field positions
  localparam int CTRL_STORE_EN = 0;
  localparam int CTRL_READ_CFG = 3;

  // the only legal low-five-bit command codes
  localparam logic [4:0] CMD_FILL = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_READ = 5'h09;
  localparam logic [4:0] CMD_CLEAR = 5'h11;

  // acceptance windows in cycles after the command write
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  localparam logic [2:0] LOAD_WINDOW = 3'h3;
  localparam logic [2:0] LOAD_LAST = STORE_WINDOW - LOAD_WINDOW;

  // programming time
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_MIN_NS = 3700000;
  localparam int PROG_TIME_MAX_NS = 4500000;
  localparam int PROG_CYCLES_MIN =
    (PROG_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // pointer low bits select the returned configuration byte
  localparam logic [1:0] SEL_FUSE_LOW = 2'h0;
  localparam logic [1:0] SEL_LOCK = 2'h1;
  localparam logic [1:0] SEL_FUSE_EXT = 2'h2;
  localparam logic [1:0] SEL_FUSE_HIGH = 2'h3;
  localparam int FUSE_SELFPRG_BIT = 0;

  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_ERASE = 2'b01,
    OP_WRITE = 2'b10
  } op_t;

  function automatic logic cmd_valid(input logic [4:0] code);
    cmd_valid = (code == CMD_FILL) || (code == CMD_ERASE) ||
                (code == CMD_WRITE) || (code == CMD_READ) ||
                (code == CMD_CLEAR);
  endfunction : cmd_valid

endpackage : prog_ctrl_pkg

// ==== rtl/prog_if.sv ====
// links the control logic to its page buffer and programming timer
`timescale 1ns/1ns
interface prog_if #(parameter int WORD_BITS = 5);
  logic buf_wr;
  logic buf_clear;
  logic [WORD_BITS-1:0] buf_waddr;
  logic [15:0] buf_wdata;
  logic buf_loaded;
  logic [WORD_BITS-1:0] rd_addr;
  logic [15:0] rd_data;
  logic tmr_start;
  logic tmr_busy;
  logic tmr_done;

  modport ctrl (output buf_wr, buf_clear, buf_waddr, buf_wdata, rd_addr,
                tmr_start,
                input buf_loaded, rd_data, tmr_busy, tmr_done);
  modport buffer (input buf_wr, buf_clear, buf_waddr, buf_wdata, rd_addr,
                  output buf_loaded, rd_data);
  modport timer (input tmr_start, output tmr_busy, tmr_done);
endinterface : prog_if

// ==== rtl/page_buffer.sv ====
// temporary page buffer, each word writable once between erasures
`timescale 1ns/1ns
module page_buffer import prog_ctrl_pkg::*; #(
  parameter int PAGE_WORDS = 32,
  parameter int WORD_BITS = 5
) (
  // system
  input wire logic clock,
  input wire logic rst_b,
  // control side
  prog_if.buffer pif
);
  logic [15:0] mem [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] used_reg, used_next;
  logic [15:0] rd_reg, rd_next;
  logic wr_ok;

  if (PAGE_WORDS != (1 << WORD_BITS)) begin : g_chk
    $error("page_buffer: PAGE_WORDS must equal 2**WORD_BITS");
  end

  // a second write to a word is dropped until the buffer is erased
  assign wr_ok = pif.buf_wr && !used_reg[pif.buf_waddr] && !pif.buf_clear;

  always_comb begin
    used_next = used_reg;
    if (pif.buf_clear) begin
      used_next = '0;
    end else if (wr_ok) begin
      used_next[pif.buf_waddr] = 1'b1;
    end
    // erased words read as all ones
    rd_next = used_reg[pif.rd_addr] ? mem[pif.rd_addr] : 16'hFFFF;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      used_reg <= '0;
      rd_reg <= 16'hFFFF;
    end else begin
      used_reg <= used_next;
      rd_reg <= rd_next;
    end
  end

  always_ff @(posedge clock) begin
    if (wr_ok) begin
      mem[pif.buf_waddr] <= pif.buf_wdata;
    end
  end

  assign pif.buf_loaded = |used_reg;
  assign pif.rd_data = rd_reg;

endmodule : page_buffer

// ==== rtl/prog_timer.sv ====
// times one erase or write from the calibrated clock
`timescale 1ns/1ns
module prog_timer import prog_ctrl_pkg::*; #(
  parameter int PROG_CYCLES = PROG_CYCLES_MIN
) (
  // system
  input wire logic clock,
  input wire logic rst_b,
  // control side
  prog_if.timer pif
);
  logic [22:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;

  if (PROG_CYCLES < 2 || PROG_CYCLES >= (1 << 23)) begin : g_chk
    $error("prog_timer: PROG_CYCLES out of range");
  end

  always_comb begin
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (busy_reg) begin
      if (cnt_reg == 23'h000000) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 23'h000001;
      end
    end else if (pif.tmr_start) begin
      busy_next = 1'b1;
      // busy for exactly PROG_CYCLES cycles, which defaults to the minimum PROG_CYCLES_MIN
      cnt_next = 23'(PROG_CYCLES - 1);
    end
  end

  // reset does not abort a running operation
  always_ff @(posedge clock) begin
    if (!rst_b && !busy_reg) begin
      cnt_reg <= 23'h000000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      busy_reg <= rst_b ? busy_next : busy_reg && busy_next;
      done_reg <= done_next;
    end
  end

  assign pif.tmr_busy = busy_reg;
  assign pif.tmr_done = done_reg;

endmodule : prog_timer

// ==== rtl/self_program_flash_control.sv ====
// self-programming control register, command windows and dispatch
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
// Operation
// - eeprom write blocks commands and fuse reads
// - programmed bits read zero, unprogrammed one
// - load within three cycles returns config byte
// - read command clears on use or timeout
// - pointer 1 gives lock, 0 fuse low
// - pointer 3 fuse high, 2 fuse extended
// - erase and write timed 3.7 to 4.5 ms
// - control bits 7 to 5 read zero
// - clear command discards the page buffer
// - pointer bits 1 to 0 pick lock or fuse
// - page write programs buffer into pointer page
// - write bit clears at end; core halted
// - erase within four cycles, core halted
// - enable alone stores data pair to buffer
// - enable clears after store or four cycles
// - only five command codes take effect
// - reset lets a running write finish
// - buffer erased after write, clear, reset
// - stores need the self-program fuse programmed
module self_program_flash_control import prog_ctrl_pkg::*; #(
  parameter int PAGE_WORDS = 32,
  parameter int WORD_BITS = 5,
  parameter int PROG_CYCLES = PROG_CYCLES_MIN
) (
  // system
  input wire logic clock,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu core
  input wire logic store_program_memory_instr,
  input wire logic load_program_memory_instr,
  input wire logic [15:0] z_pointer,
  input wire logic [15:0] data_register_pair,
  output logic cfg_read_valid,
  output logic [7:0] cfg_read_data,
  output logic cpu_halt,
  // eeprom controller and latched configuration
  input wire logic eeprom_write_busy_flag,
  input wire logic [7:0] fuse_low_byte,
  input wire logic [7:0] fuse_high_byte,
  input wire logic [7:0] fuse_extended_byte,
  input wire logic [7:0] lock_byte,
  // flash array
  output logic flash_erase_start,
  output logic flash_write_start,
  output logic [14-WORD_BITS:0] flash_page,
  input wire logic [WORD_BITS-1:0] flash_buf_addr,
  output logic [15:0] flash_buf_data
);
  prog_if #(.WORD_BITS(WORD_BITS)) pif ();

  logic [4:0] ctrl_reg, ctrl_next;
  logic [2:0] cnt_reg, cnt_next;
  op_t op_reg, op_next;
  logic cfg_valid_reg, cfg_valid_next;
  logic [7:0] cfg_data_reg, cfg_data_next;
  logic erase_reg, erase_next;
  logic write_reg, write_next;
  logic [14-WORD_BITS:0] page_reg, page_next;
  logic [31:0] prdata_reg, prdata_next;
  logic self_prog_ok;
  logic store_ok;
  logic load_ok;
  logic expire;
  logic ctrl_wr;
  logic addr_hit;

  if (WORD_BITS < 1 || WORD_BITS > 14) begin : g_chk
    $error("self_program_flash_control: WORD_BITS out of range");
  end

  // configuration bytes are passed as stored: programmed bits are zero
  function automatic logic [7:0] cfg_byte(input logic [1:0] sel);
    unique case (sel)
      SEL_FUSE_LOW: cfg_byte = fuse_low_byte;
      SEL_LOCK: cfg_byte = lock_byte;
      SEL_FUSE_EXT: cfg_byte = fuse_extended_byte;
      SEL_FUSE_HIGH: cfg_byte = fuse_high_byte;
    endcase
  endfunction : cfg_byte

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == CTRL_OFFSET) || (a == STATUS_OFFSET);
  endfunction : reg_hit

  page_buffer #(.PAGE_WORDS(PAGE_WORDS), .WORD_BITS(WORD_BITS)) u_buffer (
    .clock(clock),
    .rst_b(rst_b),
    .pif(pif)
  );

  prog_timer #(.PROG_CYCLES(PROG_CYCLES)) u_timer (
    .clock(clock),
    .rst_b(rst_b),
    .pif(pif)
  );

  assign self_prog_ok = !fuse_extended_byte[FUSE_SELFPRG_BIT];
  assign addr_hit = reg_hit(paddr);
  assign ctrl_wr = psel && penable && pwrite && (paddr == CTRL_OFFSET);

  // instructions are honoured only inside the armed window
  assign store_ok = store_program_memory_instr && ctrl_reg[CTRL_STORE_EN] &&
                    (cnt_reg != 3'h0) && !pif.tmr_busy && self_prog_ok &&
                    !eeprom_write_busy_flag;
  assign load_ok = load_program_memory_instr && (ctrl_reg == CMD_READ) &&
                   (cnt_reg > LOAD_LAST) && !eeprom_write_busy_flag;
  assign expire = !pif.tmr_busy && (ctrl_reg != CTRL_RESET) &&
                  ((cnt_reg <= 3'h1) ||
                   ((ctrl_reg == CMD_READ) && (cnt_reg == LOAD_LAST + 3'h1)));

  always_comb begin
    ctrl_next = ctrl_reg;
    cnt_next = cnt_reg;
    op_next = op_reg;
    cfg_valid_next = 1'b0;
    cfg_data_next = cfg_data_reg;
    erase_next = 1'b0;
    write_next = 1'b0;
    page_next = page_reg;
    prdata_next = prdata_reg;
    pif.buf_wr = 1'b0;
    pif.buf_clear = 1'b0;
    pif.tmr_start = 1'b0;
    pif.buf_waddr = z_pointer[WORD_BITS:1];
    pif.buf_wdata = data_register_pair;
    pif.rd_addr = flash_buf_addr;
    if (cnt_reg != 3'h0 && !pif.tmr_busy) begin
      cnt_next = cnt_reg - 3'h1;
    end
    if (store_ok) begin
      cnt_next = 3'h0;
      unique case (ctrl_reg)
        CMD_FILL: begin
          pif.buf_wr = 1'b1;
          ctrl_next = CTRL_RESET;
        end
        CMD_CLEAR: begin
          pif.buf_clear = 1'b1;
          ctrl_next = CTRL_RESET;
        end
        CMD_ERASE: begin
          pif.tmr_start = 1'b1;
          op_next = OP_ERASE;
          erase_next = 1'b1;
          page_next = z_pointer[15:WORD_BITS+1];
        end
        CMD_WRITE: begin
          pif.tmr_start = 1'b1;
          op_next = OP_WRITE;
          write_next = 1'b1;
          page_next = z_pointer[15:WORD_BITS+1];
        end
        CMD_READ: begin
          ctrl_next = CTRL_RESET;
        end
      endcase
    end else if (load_ok) begin
      cfg_valid_next = 1'b1;
      cfg_data_next = cfg_byte(z_pointer[1:0]);
      ctrl_next = CTRL_RESET;
      cnt_next = 3'h0;
    end else if (expire) begin
      ctrl_next = CTRL_RESET;
      cnt_next = 3'h0;
    end
    // enable and operation bit stay up until the timer ends or a reset clears ctrl_reg
    if (pif.tmr_done) begin
      ctrl_next = CTRL_RESET;
      op_next = OP_IDLE;
      if (op_reg == OP_WRITE) begin
        pif.buf_clear = 1'b1;
      end
    end
    // an eeprom write in the middle of loading loses the buffer
    if (eeprom_write_busy_flag && pif.buf_loaded) begin
      pif.buf_clear = 1'b1;
    end
    if (ctrl_wr && !eeprom_write_busy_flag && !pif.tmr_busy &&
        cmd_valid(pwdata[4:0])) begin
      ctrl_next = pwdata[4:0];
      cnt_next = STORE_WINDOW;
    end
    // read data captured in the setup phase
    if (psel && !penable && !pwrite) begin
      if (paddr == CTRL_OFFSET) begin
        prdata_next = {27'h0000000, ctrl_reg};
      end else if (paddr == STATUS_OFFSET) begin
        prdata_next = {28'h0000000, pif.buf_loaded, self_prog_ok,
                       eeprom_write_busy_flag, pif.tmr_busy};
      end else begin
        prdata_next = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_reg <= CTRL_RESET;
      cnt_reg <= 3'h0;
      cfg_valid_reg <= 1'b0;
      cfg_data_reg <= 8'h00;
      erase_reg <= 1'b0;
      write_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      ctrl_reg <= ctrl_next;
      cnt_reg <= cnt_next;
      cfg_valid_reg <= cfg_valid_next;
      cfg_data_reg <= cfg_data_next;
      erase_reg <= erase_next;
      write_reg <= write_next;
      prdata_reg <= prdata_next;
    end
  end

  // operation kind and page survive a reset taken mid-operation
  always_ff @(posedge clock) begin
    if (!rst_b && !pif.tmr_busy) begin
      op_reg <= OP_IDLE;
      page_reg <= '0;
    end else begin
      op_reg <= op_next;
      page_reg <= page_next;
    end
  end

  assign pready = psel && penable;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata = prdata_reg;
  assign cfg_read_valid = cfg_valid_reg;
  assign cfg_read_data = cfg_data_reg;
  assign cpu_halt = pif.tmr_busy;
  assign flash_erase_start = erase_reg;
  assign flash_write_start = write_reg;
  assign flash_page = page_reg;
  assign flash_buf_data = pif.rd_data;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_eeprom_blocks_cmd: assert property (
    (ctrl_wr && eeprom_write_busy_flag) |=> (cnt_reg != STORE_WINDOW))
    else $error("command accepted during eeprom write");

  a_eeprom_blocks_read: assert property (
    (load_program_memory_instr && eeprom_write_busy_flag) |=> !cfg_read_valid)
    else $error("configuration read during eeprom write");

  a_bad_cmd_ignored: assert property (
    (ctrl_wr && !cmd_valid(pwdata[4:0])) |=> (cnt_reg != STORE_WINDOW))
    else $error("illegal command code took effect");

  a_reserved_zero: assert property (
    (psel && !penable && !pwrite && paddr == CTRL_OFFSET)
      |=> (prdata[31:5] == 27'h0000000))
    else $error("reserved control bits not zero");

  a_lock_select: assert property (
    (load_ok && z_pointer[1:0] == SEL_LOCK)
      |=> (cfg_read_valid && cfg_read_data == $past(lock_byte)))
    else $error("lock byte not returned");

  a_high_select: assert property (
    (load_ok && z_pointer[1:0] == SEL_FUSE_HIGH)
      |=> (cfg_read_valid && cfg_read_data == $past(fuse_high_byte)))
    else $error("fuse high byte not returned");

  a_read_timeout: assert property (
    (cnt_reg == STORE_WINDOW && ctrl_reg == CMD_READ)
      |-> ##[1:3] (ctrl_reg == CTRL_RESET))
    else $error("read command did not clear");

  a_store_timeout: assert property (
    (cnt_reg == STORE_WINDOW && ctrl_reg[CTRL_STORE_EN])
      |-> ##[1:4] (!ctrl_reg[CTRL_STORE_EN] || cpu_halt))
    else $error("enable bit outlived its window");

  a_fuse_gate: assert property (
    (store_program_memory_instr && !self_prog_ok)
      |=> !(flash_erase_start || flash_write_start))
    else $error("store acted with self-program fuse clear");

  a_halt_holds: assert property (
    $rose(cpu_halt) |-> (cpu_halt && ctrl_reg[CTRL_STORE_EN]) [*8])
    else $error("halt or enable dropped early");

endmodule : self_program_flash_control

// ==== verification/cpu_core_model.sv ====
// core-side model issuing store and load instruction pulses
`timescale 1ns/1ns
module cpu_core_model (
  // system
  input wire logic clock,
  // instruction strobes and operands
  output logic store_program_memory_instr,
  output logic load_program_memory_instr,
  output logic [15:0] z_pointer,
  output logic [15:0] data_register_pair
);
  initial begin
    store_program_memory_instr = 1'b0;
    load_program_memory_instr = 1'b0;
    z_pointer = 16'h0000;
    data_register_pair = 16'h0000;
  end

  // gap idle cycles first, so late instructions can miss their window
  task automatic issue(input logic is_load, input logic [15:0] z,
                       input logic [15:0] d, input int gap);
    repeat (gap) @(posedge clock);
    z_pointer <= z;
    data_register_pair <= d;
    store_program_memory_instr <= !is_load;
    load_program_memory_instr <= is_load;
    @(posedge clock);
    store_program_memory_instr <= 1'b0;
    load_program_memory_instr <= 1'b0;
  endtask : issue
endmodule : cpu_core_model

// ==== verification/self_program_flash_control_test.sv ====
// self-checking bench for the self-programming flash control block
`timescale 1ns/1ns
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("Error at %0t: got %0h expected %0h", $time, g, e); \
  end \
end
module self_program_flash_control_test import prog_ctrl_pkg::*;;
  localparam int PROG = 20;
  logic clock, rst_b, psel, penable, pwrite, pready, pslverr, rerr, ok;
  logic [7:0] paddr, cfg_read_data, fuse_low_byte, fuse_high_byte;
  logic [7:0] fuse_extended_byte, lock_byte;
  logic [31:0] pwdata, prdata, rdata;
  logic store_program_memory_instr, load_program_memory_instr;
  logic [15:0] z_pointer, data_register_pair, flash_buf_data;
  logic cfg_read_valid, cpu_halt, eeprom_write_busy_flag;
  logic flash_erase_start, flash_write_start;
  logic [9:0] flash_page;
  logic [4:0] flash_buf_addr;
  logic [7:0] exp_cfg [4];
  int error_cnt = 0;
  int total_checks = 0;
  int halt_cnt = 0;
  int halt_base = 0;

  self_program_flash_control #(
    .PROG_CYCLES(PROG)
  ) i_self_program_flash_control (
    .clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .store_program_memory_instr,
    .load_program_memory_instr, .z_pointer, .data_register_pair,
    .cfg_read_valid, .cfg_read_data, .cpu_halt, .eeprom_write_busy_flag,
    .fuse_low_byte, .fuse_high_byte, .fuse_extended_byte, .lock_byte,
    .flash_erase_start, .flash_write_start, .flash_page, .flash_buf_addr,
    .flash_buf_data);

  cpu_core_model i_cpu_core_model (
    .clock, .store_program_memory_instr, .load_program_memory_instr,
    .z_pointer, .data_register_pair);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (cpu_halt === 1'b1) begin
      halt_cnt <= halt_cnt + 1;
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdata, e)
  endtask : rd_chk

  // buffer read port is registered, so allow one edge of latency
  task automatic buf_chk(input logic [4:0] a, input logic [15:0] e);
    @(posedge clock);
    flash_buf_addr <= a;
    repeat (2) @(posedge clock);
    #1;
    `CHK(flash_buf_data, e)
  endtask : buf_chk

  task automatic halt_end();
    int n;
    n = 0;
    while (cpu_halt === 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    #1;
    `CHK(halt_cnt - halt_base, PROG)
  endtask : halt_end

  initial begin
    #100000;
    error_cnt++;
    final_report();
  end

  initial begin
    exp_cfg = '{8'h5A, 8'h3C, 8'hFE, 8'hA5};
    fuse_low_byte = exp_cfg[0];
    lock_byte = exp_cfg[1];
    fuse_extended_byte = exp_cfg[2];
    fuse_high_byte = exp_cfg[3];
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    eeprom_write_busy_flag = 1'b0;
    flash_buf_addr = 5'h00;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    rd_chk(CTRL_OFFSET, 32'h0);
    rd_chk(STATUS_OFFSET, 32'h4);
    apb(1'b0, 8'h08, 32'h0);
    `CHK(rerr, 1'b1)
    `CHK(rdata, 32'h0)
    // every code with the unused top bits set
    for (int c = 0; c < 32; c++) begin
      apb(1'b1, CTRL_OFFSET, 32'hE0 | 32'(c));
      ok = c == 1 || c == 3 || c == 5 || c == 9 || c == 17;
      rd_chk(CTRL_OFFSET, ok ? 32'(c) : 32'h0);
      repeat (5) @(posedge clock);
      rd_chk(CTRL_OFFSET, 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CTRL_OFFSET, 32'h9);
      i_cpu_core_model.issue(1'b1, 16'(i), 16'h0, 0);
      #1;
      `CHK(cfg_read_valid, 1'b1)
      `CHK(cfg_read_data, exp_cfg[i])
    end
    i_cpu_core_model.issue(1'b1, 16'h1, 16'h0, 1);
    #1;
    `CHK(cfg_read_valid, 1'b0)
    apb(1'b1, CTRL_OFFSET, 32'h9);
    i_cpu_core_model.issue(1'b1, 16'h1, 16'h0, 3);
    #1;
    `CHK(cfg_read_valid, 1'b0)
    @(posedge clock);
    eeprom_write_busy_flag <= 1'b1;
    rd_chk(STATUS_OFFSET, 32'h6);
    apb(1'b1, CTRL_OFFSET, 32'h9);
    i_cpu_core_model.issue(1'b1, 16'h0, 16'h0, 0);
    #1;
    `CHK(cfg_read_valid, 1'b0)
    @(posedge clock);
    eeprom_write_busy_flag <= 1'b0;
    rd_chk(STATUS_OFFSET, 32'h4);
    apb(1'b1, CTRL_OFFSET, 32'h1);
    i_cpu_core_model.issue(1'b0, 16'h0043, 16'h1234, 0);
    apb(1'b1, CTRL_OFFSET, 32'h1);
    i_cpu_core_model.issue(1'b0, 16'h0046, 16'h5678, 3);
    apb(1'b1, CTRL_OFFSET, 32'h1);
    i_cpu_core_model.issue(1'b0, 16'h0042, 16'h9ABC, 0);
    rd_chk(STATUS_OFFSET, 32'hC);
    buf_chk(5'h1, 16'h1234);
    buf_chk(5'h3, 16'h5678);
    halt_base = halt_cnt;
    apb(1'b1, CTRL_OFFSET, 32'h5);
    i_cpu_core_model.issue(1'b0, 16'h0040, 16'hDEAD, 0);
    #1;
    `CHK(flash_write_start, 1'b1)
    `CHK(flash_page, 10'h001)
    `CHK(cpu_halt, 1'b1)
    apb(1'b1, CTRL_OFFSET, 32'h1);
    rd_chk(CTRL_OFFSET, 32'h5);
    buf_chk(5'h1, 16'h1234);
    halt_end();
    rd_chk(CTRL_OFFSET, 32'h0);
    buf_chk(5'h1, 16'hFFFF);
    apb(1'b1, CTRL_OFFSET, 32'h1);
    i_cpu_core_model.issue(1'b0, 16'h0044, 16'hA55A, 0);
    buf_chk(5'h2, 16'hA55A);
    apb(1'b1, CTRL_OFFSET, 32'h11);
    i_cpu_core_model.issue(1'b0, 16'h0044, 16'h0, 0);
    buf_chk(5'h2, 16'hFFFF);
    rd_chk(STATUS_OFFSET, 32'h4);
    fuse_extended_byte <= 8'hFF;
    rd_chk(STATUS_OFFSET, 32'h0);
    apb(1'b1, CTRL_OFFSET, 32'h1);
    i_cpu_core_model.issue(1'b0, 16'h0048, 16'hBEEF, 0);
    buf_chk(5'h4, 16'hFFFF);
    @(posedge clock);
    fuse_extended_byte <= 8'hFE;
    halt_base = halt_cnt;
    apb(1'b1, CTRL_OFFSET, 32'h3);
    i_cpu_core_model.issue(1'b0, 16'h0080, 16'h0, 0);
    #1;
    `CHK(flash_erase_start, 1'b1)
    `CHK(flash_page, 10'h002)
    // reset in mid-erase must not cut the operation short
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    `CHK(cpu_halt, 1'b1)
    halt_end();
    final_report();
  end
endmodule : self_program_flash_control_test
